// >>> rtl/xfer_ctl_pkg.sv
// constants and carrier types for the two-channel transfer controller control block
package xfer_ctl_pkg;

    localparam int NCH = 2;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] IRQ_MASK_SET_OFS = 12'h018;
    localparam logic [11:0] IRQ_MASK_CLEAR_OFS = 12'h01C;
    localparam logic [11:0] IRQ_MASK_VIEW_OFS = 12'h020;
    localparam logic [11:0] IRQ_FLAG_VIEW_OFS = 12'h024;
    localparam logic [11:0] CHAN_START_CTL_OFS = 12'h028;
    localparam logic [11:0] CHAN_STOP_CTL_OFS = 12'h02C;
    localparam logic [11:0] CHAN_STATE_VIEW_OFS = 12'h030;
    localparam logic [11:0] SRC_POINTER0_OFS = 12'h03C;
    localparam logic [11:0] DST_POINTER0_OFS = 12'h040;
    localparam logic [11:0] LIST_POINTER0_OFS = 12'h044;
    localparam logic [11:0] SRC_POINTER1_OFS = 12'h064;
    localparam logic [11:0] DST_POINTER1_OFS = 12'h068;
    localparam logic [11:0] LIST_POINTER1_OFS = 12'h06C;

    // ------------------------------------------------------------------
    // field positions (low bit of each two-channel group)
    // ------------------------------------------------------------------
    localparam int BLOCK_DONE_POS = 0;
    localparam int CHAIN_DONE_POS = 8;
    localparam int BUS_FAULT_POS = 16;
    localparam int CHAN_ON_POS = 0;
    localparam int CHAN_FREEZE_POS = 8;
    localparam int CHAN_RELEASE_POS = 24;
    localparam int CHAN_OFF_POS = 0;
    localparam int CHAN_CONTINUE_POS = 8;
    localparam int FIFO_DRAINED_POS = 16;
    localparam int HALTED_FLAG_POS = 24;
    localparam int LIST_PORT_SEL_POS = 0;
    localparam logic [1:0] LIST_PORT0 = 2'h0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] CHAN_STATE_RESET = 32'h00FF_0000;
    localparam logic [31:0] POINTER_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // carriers between this block and the transfer engine
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NCH-1:0] block_done;
        logic [NCH-1:0] chain_done;
        logic [NCH-1:0] bus_fault;
        logic [NCH-1:0] halt_req;
        logic [NCH-1:0] fifo_empty;
        logic [NCH-1:0] engine_idle;
    } engine_evt_t;

    typedef struct packed {
        logic [NCH-1:0] chan_on;
        logic [NCH-1:0] chan_freeze;
        logic [NCH-1:0] halted_flag;
        logic [NCH-1:0] abort;
        logic [NCH-1:0] list_fetch_en;
    } engine_ctl_t;

endpackage : xfer_ctl_pkg

// >>> rtl/xfer_ctl.sv
// apb register front end and channel control of the two-channel transfer controller
`timescale 1ns/1ps

module xfer_ctl (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire xfer_ctl_pkg::engine_evt_t EVT,
    output xfer_ctl_pkg::engine_ctl_t CTL,
    output logic [xfer_ctl_pkg::NCH-1:0][31:0] SOURCE_POINTER,
    output logic [xfer_ctl_pkg::NCH-1:0][31:0] TARGET_POINTER,
    output logic [xfer_ctl_pkg::NCH-1:0][31:0] NEXT_ITEM_POINTER,
    output logic IRQ
);

    localparam int N = xfer_ctl_pkg::NCH;

    // ------------------------------------------------------------------
    // apb access decode
    // ------------------------------------------------------------------
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic setup_cyc;
    logic wr_fire;
    logic rd_fire;
    logic hit;
    logic [31:0] rd_value;

    assign setup_cyc = PSEL && !PENABLE;
    assign wr_fire = PSEL && PENABLE && pready_reg && PWRITE;
    assign rd_fire = PSEL && PENABLE && pready_reg && !PWRITE;

    function automatic logic wr_at(input logic [11:0] ofs, input logic fire, input logic [11:0] a);
        wr_at = fire && (a == ofs);
    endfunction : wr_at

    logic [31:0] wmask_set;
    logic [31:0] wmask_clr;
    logic [31:0] wstart;
    logic [31:0] wstop;

    assign wmask_set = wr_at(xfer_ctl_pkg::IRQ_MASK_SET_OFS, wr_fire, PADDR) ? PWDATA : 32'h0000_0000;
    assign wmask_clr = wr_at(xfer_ctl_pkg::IRQ_MASK_CLEAR_OFS, wr_fire, PADDR) ? PWDATA : 32'h0000_0000;
    assign wstart = wr_at(xfer_ctl_pkg::CHAN_START_CTL_OFS, wr_fire, PADDR) ? PWDATA : 32'h0000_0000;
    assign wstop = wr_at(xfer_ctl_pkg::CHAN_STOP_CTL_OFS, wr_fire, PADDR) ? PWDATA : 32'h0000_0000;

    // ------------------------------------------------------------------
    // per-channel command fields
    // ------------------------------------------------------------------
    logic [N-1:0] cmd_on;
    logic [N-1:0] cmd_freeze;
    logic [N-1:0] cmd_release;
    logic [N-1:0] cmd_off;
    logic [N-1:0] cmd_continue;

    assign cmd_on = wstart[xfer_ctl_pkg::CHAN_ON_POS +: N];
    assign cmd_freeze = wstart[xfer_ctl_pkg::CHAN_FREEZE_POS +: N];
    assign cmd_release = wstart[xfer_ctl_pkg::CHAN_RELEASE_POS +: N];
    assign cmd_off = wstop[xfer_ctl_pkg::CHAN_OFF_POS +: N];
    assign cmd_continue = wstop[xfer_ctl_pkg::CHAN_CONTINUE_POS +: N];

    // ------------------------------------------------------------------
    // interrupt mask
    // ------------------------------------------------------------------
    logic [N-1:0] mask_blk_reg;
    logic [N-1:0] mask_chn_reg;
    logic [N-1:0] mask_flt_reg;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mask_blk_reg <= '0;
            mask_chn_reg <= '0;
            mask_flt_reg <= '0;
        end else begin
            // ones set or clear, zeros leave the bit alone
            mask_blk_reg <= (mask_blk_reg | wmask_set[xfer_ctl_pkg::BLOCK_DONE_POS +: N])
                & ~wmask_clr[xfer_ctl_pkg::BLOCK_DONE_POS +: N];
            mask_chn_reg <= (mask_chn_reg | wmask_set[xfer_ctl_pkg::CHAIN_DONE_POS +: N])
                & ~wmask_clr[xfer_ctl_pkg::CHAIN_DONE_POS +: N];
            mask_flt_reg <= (mask_flt_reg | wmask_set[xfer_ctl_pkg::BUS_FAULT_POS +: N])
                & ~wmask_clr[xfer_ctl_pkg::BUS_FAULT_POS +: N];
        end
    end

    // ------------------------------------------------------------------
    // event flags, cleared by reading the flag view; a new event wins
    // ------------------------------------------------------------------
    logic [N-1:0] flag_blk_reg;
    logic [N-1:0] flag_chn_reg;
    logic [N-1:0] flag_flt_reg;
    logic flag_rd;

    assign flag_rd = rd_fire && (PADDR == xfer_ctl_pkg::IRQ_FLAG_VIEW_OFS);

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            flag_blk_reg <= '0;
            flag_chn_reg <= '0;
            flag_flt_reg <= '0;
        end else begin
            flag_blk_reg <= (flag_rd ? '0 : flag_blk_reg) | EVT.block_done;
            flag_chn_reg <= (flag_rd ? '0 : flag_chn_reg) | EVT.chain_done;
            flag_flt_reg <= (flag_rd ? '0 : flag_flt_reg) | EVT.bus_fault;
        end
    end

    logic irq_reg;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |((flag_blk_reg & mask_blk_reg) | (flag_chn_reg & mask_chn_reg)
                | (flag_flt_reg & mask_flt_reg));
        end
    end

    // ------------------------------------------------------------------
    // channel state
    // ------------------------------------------------------------------
    logic [N-1:0] on_reg;
    logic [N-1:0] freeze_reg;
    logic [N-1:0] halted_reg;
    logic [N-1:0] abort_reg;
    logic [N-1:0] drained_reg;
    logic [N-1:0] fetch_en_reg;
    logic [N-1:0] off_done;

    // a disable completes only once the engine has dropped its bus access
    assign off_done = abort_reg & EVT.engine_idle;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            on_reg <= '0;
            abort_reg <= '0;
        end else begin
            abort_reg <= (abort_reg | (cmd_off & on_reg)) & ~off_done;
            on_reg <= (on_reg | (cmd_on & ~abort_reg)) & ~off_done;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            freeze_reg <= '0;
        end else begin
            freeze_reg <= (freeze_reg | (cmd_freeze & on_reg)) & ~cmd_continue & ~off_done;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            halted_reg <= '0;
        end else begin
            halted_reg <= (halted_reg & ~cmd_release & ~off_done) | (EVT.halt_req & on_reg);
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            drained_reg <= xfer_ctl_pkg::CHAN_STATE_RESET[xfer_ctl_pkg::FIFO_DRAINED_POS +: N];
        end else begin
            drained_reg <= EVT.fifo_empty;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            fetch_en_reg <= '0;
        end else begin
            // chain end stops further descriptor fetches until re-enabled
            fetch_en_reg <= (fetch_en_reg | (cmd_on & ~abort_reg)) & ~EVT.chain_done & ~off_done;
        end
    end

    // ------------------------------------------------------------------
    // channel pointers
    // ------------------------------------------------------------------
    logic [N-1:0][31:0] src_reg;
    logic [N-1:0][31:0] dst_reg;
    logic [N-1:0][31:0] list_reg;
    logic [11:0] src_ofs [N];
    logic [11:0] dst_ofs [N];
    logic [11:0] list_ofs [N];

    assign src_ofs[0] = xfer_ctl_pkg::SRC_POINTER0_OFS;
    assign src_ofs[1] = xfer_ctl_pkg::SRC_POINTER1_OFS;
    assign dst_ofs[0] = xfer_ctl_pkg::DST_POINTER0_OFS;
    assign dst_ofs[1] = xfer_ctl_pkg::DST_POINTER1_OFS;
    assign list_ofs[0] = xfer_ctl_pkg::LIST_POINTER0_OFS;
    assign list_ofs[1] = xfer_ctl_pkg::LIST_POINTER1_OFS;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            src_reg <= {N{xfer_ctl_pkg::POINTER_RESET}};
            dst_reg <= {N{xfer_ctl_pkg::POINTER_RESET}};
            list_reg <= {N{xfer_ctl_pkg::POINTER_RESET}};
        end else begin
            for (int i = 0; i < N; i++) begin
                if (wr_at(src_ofs[i], wr_fire, PADDR)) begin
                    src_reg[i] <= PWDATA;
                end
                if (wr_at(dst_ofs[i], wr_fire, PADDR)) begin
                    dst_reg[i] <= PWDATA;
                end
                if (wr_at(list_ofs[i], wr_fire, PADDR)) begin
                    list_reg[i] <= PWDATA;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // read mux and apb answer
    // ------------------------------------------------------------------
    always_comb begin
        rd_value = 32'h0000_0000;
        hit = 1'b1;
        unique case (PADDR)
            xfer_ctl_pkg::IRQ_MASK_SET_OFS,
            xfer_ctl_pkg::IRQ_MASK_CLEAR_OFS,
            xfer_ctl_pkg::CHAN_START_CTL_OFS,
            xfer_ctl_pkg::CHAN_STOP_CTL_OFS: begin
                rd_value = 32'h0000_0000;
            end
            xfer_ctl_pkg::IRQ_MASK_VIEW_OFS: begin
                rd_value[xfer_ctl_pkg::BLOCK_DONE_POS +: N] = mask_blk_reg;
                rd_value[xfer_ctl_pkg::CHAIN_DONE_POS +: N] = mask_chn_reg;
                rd_value[xfer_ctl_pkg::BUS_FAULT_POS +: N] = mask_flt_reg;
            end
            xfer_ctl_pkg::IRQ_FLAG_VIEW_OFS: begin
                rd_value[xfer_ctl_pkg::BLOCK_DONE_POS +: N] = flag_blk_reg;
                rd_value[xfer_ctl_pkg::CHAIN_DONE_POS +: N] = flag_chn_reg;
                rd_value[xfer_ctl_pkg::BUS_FAULT_POS +: N] = flag_flt_reg;
            end
            xfer_ctl_pkg::CHAN_STATE_VIEW_OFS: begin
                // unused empty positions read one, matching the reset image
                rd_value = xfer_ctl_pkg::CHAN_STATE_RESET;
                rd_value[xfer_ctl_pkg::CHAN_ON_POS +: N] = on_reg;
                rd_value[xfer_ctl_pkg::CHAN_FREEZE_POS +: N] = freeze_reg;
                rd_value[xfer_ctl_pkg::FIFO_DRAINED_POS +: N] = drained_reg;
                rd_value[xfer_ctl_pkg::HALTED_FLAG_POS +: N] = halted_reg;
            end
            default: begin
                hit = 1'b0;
                for (int i = 0; i < N; i++) begin
                    if (PADDR == src_ofs[i]) begin
                        rd_value = src_reg[i];
                        hit = 1'b1;
                    end
                    if (PADDR == dst_ofs[i]) begin
                        rd_value = dst_reg[i];
                        hit = 1'b1;
                    end
                    if (PADDR == list_ofs[i]) begin
                        rd_value = list_reg[i];
                        hit = 1'b1;
                    end
                end
            end
        endcase
    end

    // the answer is prepared in the setup cycle, so every access ends after one access cycle
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup_cyc;
            pslverr_reg <= setup_cyc && !hit;
            prdata_reg <= (setup_cyc && !PWRITE && hit) ? rd_value : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign IRQ = irq_reg;
    assign CTL = '{chan_on: on_reg, chan_freeze: freeze_reg, halted_flag: halted_reg, abort: abort_reg,
                   list_fetch_en: fetch_en_reg};
    assign SOURCE_POINTER = src_reg;
    assign TARGET_POINTER = dst_reg;
    assign NEXT_ITEM_POINTER = list_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    mask_set_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (wmask_set[xfer_ctl_pkg::BLOCK_DONE_POS] && !wmask_clr[xfer_ctl_pkg::BLOCK_DONE_POS])
        |=> mask_blk_reg[0])
        else $error("mask set write did not enable source");

    mask_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
        wmask_clr[xfer_ctl_pkg::BUS_FAULT_POS + 1] |=> !mask_flt_reg[1])
        else $error("mask clear write did not disable source");

    mask_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (wmask_set == 32'h0000_0000 && wmask_clr == 32'h0000_0000) |=> $stable(mask_chn_reg))
        else $error("mask changed without a one written");

    flag_catch_a: assert property (@(posedge CLK) disable iff (!RESETN)
        EVT.block_done[0] |=> flag_blk_reg[0])
        else $error("buffer finish flag lost");

    irq_follow_a: assert property (@(posedge CLK) disable iff (!RESETN)
        ((flag_blk_reg & mask_blk_reg) != '0) |=> IRQ)
        else $error("interrupt missing for enabled flag");

    irq_quiet_a: assert property (@(posedge CLK) disable iff (!RESETN)
        ((flag_blk_reg & mask_blk_reg) == '0 && (flag_chn_reg & mask_chn_reg) == '0
        && (flag_flt_reg & mask_flt_reg) == '0) |=> !IRQ)
        else $error("interrupt without enabled flag");

    chan_enable_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (cmd_on[0] && !abort_reg[0]) |=> on_reg[0])
        else $error("channel not enabled by start write");

    freeze_set_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (cmd_freeze[0] && on_reg[0] && !cmd_continue[0] && !off_done[0]) |=> freeze_reg[0])
        else $error("channel not frozen");

    stall_release_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (cmd_release[0] && !EVT.halt_req[0]) |=> !halted_reg[0])
        else $error("stall not released");

    disable_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
        (abort_reg[0] && !EVT.engine_idle[0]) |=> on_reg[0] && abort_reg[0])
        else $error("channel left before engine idle");

    fetch_stop_a: assert property (@(posedge CLK) disable iff (!RESETN)
        EVT.chain_done[0] |=> !fetch_en_reg[0] ##1 (!fetch_en_reg[0] || $past(cmd_on[0])))
        else $error("list fetch still enabled after chain end");

    apb_answer_a: assert property (@(posedge CLK) disable iff (!RESETN)
        setup_cyc |=> PREADY ##1 !PREADY)
        else $error("apb answer not one cycle after setup");

endmodule : xfer_ctl

// >>> bench/engine_model.sv
// behavioural transfer engine standing behind the event and control carriers
`timescale 1ns/1ps

module engine_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] kick,
    input wire xfer_ctl_pkg::engine_ctl_t ctl,
    output xfer_ctl_pkg::engine_evt_t evt
);
    logic [7:0] pulse_reg;
    logic [1:0][1:0] idle_cnt_reg;

    // ------------------------------------------------------------------
    // event pulses one cycle after the bench asks for them
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_reg <= 8'h00;
        end else begin
            pulse_reg <= kick;
        end
    end

    // ------------------------------------------------------------------
    // slow abort: the bus access winds down three cycles after abort
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_reg <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                idle_cnt_reg[i] <= !ctl.abort[i] ? 2'h0 : (idle_cnt_reg[i] == 2'h3 ? 2'h3 : idle_cnt_reg[i] + 2'h1);
            end
        end
    end

    // fifo holds data only while its channel runs
    assign evt = {pulse_reg[1:0], pulse_reg[3:2], pulse_reg[5:4], pulse_reg[7:6], ~ctl.chan_on,
                  ~ctl.chan_on[1] | (idle_cnt_reg[1] == 2'h3), ~ctl.chan_on[0] | (idle_cnt_reg[0] == 2'h3)};

endmodule : engine_model

// >>> bench/tb_top.sv
// self-checking bench for the transfer controller control block
`timescale 1ns/1ps

module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] kick = 8'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    xfer_ctl_pkg::engine_evt_t evt;
    xfer_ctl_pkg::engine_ctl_t ctl;
    logic [1:0][31:0] src_ptr;
    logic [1:0][31:0] dst_ptr;
    logic [1:0][31:0] nxt_ptr;
    logic [31:0] r;
    logic e;
    int fails = 0;
    int compares = 0;
    logic [11:0] ptr_ofs [6] = '{xfer_ctl_pkg::SRC_POINTER0_OFS, xfer_ctl_pkg::DST_POINTER0_OFS,
        xfer_ctl_pkg::LIST_POINTER0_OFS, xfer_ctl_pkg::SRC_POINTER1_OFS, xfer_ctl_pkg::DST_POINTER1_OFS,
        xfer_ctl_pkg::LIST_POINTER1_OFS};
    logic [11:0] wo_ofs [4] = '{xfer_ctl_pkg::IRQ_MASK_SET_OFS, xfer_ctl_pkg::IRQ_MASK_CLEAR_OFS,
        xfer_ctl_pkg::CHAN_START_CTL_OFS, xfer_ctl_pkg::CHAN_STOP_CTL_OFS};

    xfer_ctl i_xfer_ctl (.CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EVT(evt),
        .CTL(ctl), .SOURCE_POINTER(src_ptr), .TARGET_POINTER(dst_ptr), .NEXT_ITEM_POINTER(nxt_ptr), .IRQ(irq));

    engine_model i_engine_model (.clk(clk), .rst_n(rst_n), .kick(kick), .ctl(ctl), .evt(evt));

    initial begin
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // bus master and comparison tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        check(32'(e), 32'h0, "write refused");
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(r, exp, what);
    endtask : rd

    task automatic kick_evt(input logic [7:0] v);
        @(posedge clk);
        kick <= v;
        @(posedge clk);
        kick <= 8'h00;
    endtask : kick_evt

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(xfer_ctl_pkg::CHAN_STATE_VIEW_OFS, xfer_ctl_pkg::CHAN_STATE_RESET, "state reset");
        rd(xfer_ctl_pkg::IRQ_MASK_VIEW_OFS, 32'h0, "mask reset");
        for (int k = 0; k < 4; k++)
            rd(wo_ofs[k], 32'h0, "write-only read");
        for (int k = 0; k < 6; k++)
            rd(ptr_ofs[k], 32'h0, "pointer reset");
        for (int k = 0; k < 6; k++)
            wr(ptr_ofs[k], 32'h5A00_0000 + 32'(k) * 32'h10);
        for (int k = 0; k < 6; k++)
            rd(ptr_ofs[k], 32'h5A00_0000 + 32'(k) * 32'h10, "pointer readback");
        for (int k = 0; k < 2; k++) begin
            check(src_ptr[k], 32'h5A00_0000 + 32'(3 * k) * 32'h10, "source port");
            check(dst_ptr[k], 32'h5A00_0010 + 32'(3 * k) * 32'h10, "target port");
            check(nxt_ptr[k], 32'h5A00_0020 + 32'(3 * k) * 32'h10, "list port");
        end
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        check(32'(e), 32'h1, "unmapped write");
        wr(xfer_ctl_pkg::IRQ_MASK_VIEW_OFS, 32'hFFFF_FFFF);
        wr(xfer_ctl_pkg::IRQ_MASK_SET_OFS, 32'h0003_0303);
        rd(xfer_ctl_pkg::IRQ_MASK_VIEW_OFS, 32'h0003_0303, "mask set");
        wr(xfer_ctl_pkg::IRQ_MASK_CLEAR_OFS, 32'h0000_0101);
        rd(xfer_ctl_pkg::IRQ_MASK_VIEW_OFS, 32'h0003_0202, "mask clear");
        wr(xfer_ctl_pkg::IRQ_MASK_SET_OFS, 32'h0);
        wr(xfer_ctl_pkg::IRQ_MASK_CLEAR_OFS, 32'h0);
        rd(xfer_ctl_pkg::IRQ_MASK_VIEW_OFS, 32'h0003_0202, "zero write");
        wr(xfer_ctl_pkg::IRQ_MASK_CLEAR_OFS, 32'h0003_0303);
        wr(xfer_ctl_pkg::IRQ_MASK_SET_OFS, 32'h0000_0001);
        wr(xfer_ctl_pkg::CHAN_START_CTL_OFS, 32'h1);
        rd(xfer_ctl_pkg::CHAN_STATE_VIEW_OFS, 32'h00FE_0001, "enabled");
        check(32'(ctl.chan_on), 32'h1, "chan on");
        check(32'(ctl.list_fetch_en), 32'h1, "list fetch on");
        wr(xfer_ctl_pkg::CHAN_START_CTL_OFS, 32'h100);
        rd(xfer_ctl_pkg::CHAN_STATE_VIEW_OFS, 32'h00FE_0101, "frozen");
        check(32'(ctl.chan_freeze), 32'h1, "freeze out");
        wr(xfer_ctl_pkg::CHAN_STOP_CTL_OFS, 32'h100);
        rd(xfer_ctl_pkg::CHAN_STATE_VIEW_OFS, 32'h00FE_0001, "continued");
        kick_evt(8'h40);
        repeat (2) @(posedge clk);
        rd(xfer_ctl_pkg::CHAN_STATE_VIEW_OFS, 32'h01FE_0001, "stalled");
        check(32'(ctl.halted_flag), 32'h1, "halt out");
        wr(xfer_ctl_pkg::CHAN_START_CTL_OFS, 32'h0100_0000);
        rd(xfer_ctl_pkg::CHAN_STATE_VIEW_OFS, 32'h00FE_0001, "released");
        kick_evt(8'h01);
        repeat (3) @(posedge clk);
        check(32'(irq), 32'h1, "irq raised");
        rd(xfer_ctl_pkg::IRQ_FLAG_VIEW_OFS, 32'h1, "block done");
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h0, "irq dropped");
        kick_evt(8'h04);
        repeat (3) @(posedge clk);
        check(32'(irq), 32'h0, "masked source");
        check(32'(ctl.list_fetch_en), 32'h0, "list fetch off");
        rd(xfer_ctl_pkg::IRQ_FLAG_VIEW_OFS, 32'h100, "chain done");
        kick_evt(8'h20);
        repeat (2) @(posedge clk);
        rd(xfer_ctl_pkg::IRQ_FLAG_VIEW_OFS, 32'h0002_0000, "bus fault");
        wr(xfer_ctl_pkg::CHAN_STOP_CTL_OFS, 32'h1);
        @(posedge clk);
        check(32'(ctl.abort), 32'h1, "abort");
        do begin
            apb(1'b0, xfer_ctl_pkg::CHAN_STATE_VIEW_OFS, 32'h0);
        end while (r[0] !== 1'b0);
        rd(xfer_ctl_pkg::CHAN_STATE_VIEW_OFS, xfer_ctl_pkg::CHAN_STATE_RESET, "disabled");
        check(32'(ctl.chan_on), 32'h0, "chan off");
        wrap_up();
    end

endmodule : tb_top
